// >>> hdl/sbst_params.svh
// Purpose: Constants of the SRAM boundary-scan test port
// Assumes: Included by bare name from the package and the design files
// Notes:   Widths, instruction codes, capture pattern and identification fields
`ifndef SBST_PARAMS_SVH
`define SBST_PARAMS_SVH

// Register lengths
`define SBST_IR_W        3
`define SBST_ID_W        32
`define SBST_BSR_W       69

// Instruction codes
`define SBST_INS_EXTEST  3'h0
`define SBST_INS_IDREAD  3'h1
`define SBST_INS_SAMPZ   3'h2
`define SBST_INS_SAMPLE  3'h4
`define SBST_INS_BYPASS  3'h7

// Instruction capture pattern
`define SBST_IR_CAPTURE  3'h1

// Identification field defaults; these values are arbitrary
`define SBST_ID_REV_DFLT 3'h5
`define SBST_ID_DEV_DFLT 17'h0a5a5
`define SBST_ID_VEN_DFLT 11'h2aa

// Rising edges of held mode select that always reach reset
`define SBST_RESET_EDGES 3'h5

`endif

// >>> hdl/sbst_pkg.sv
// Purpose: Types of the SRAM boundary-scan test port
// Assumes: sbst_params.svh gives the widths
// Notes:   States carry no codes; the test pins travel as one struct
`include "sbst_params.svh"

package sbst_pkg;

	// Controller states
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} sbst_state_t;

	// Data register placed in the serial path
	typedef enum logic [1:0] {
		SEL_BSR, SEL_ID, SEL_BYP
	} sbst_sel_t;

	// Test pins from the external controller
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} sbst_jtag_t;

endpackage

// >>> hdl/sbst_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Each bit is a level from outside the mclk domain
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ns

module sbst_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_b,
	// Asynchronous levels and their synchronised copy
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// Two stages, cleared by reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// >>> hdl/sbst_tap.sv
// Purpose: Boundary-scan test access port of a pipelined SRAM
// Assumes: Test clock is sampled by mclk at several samples per test clock phase
// Notes:   rst_b stands for the internal power-up reset of the port
//
// How it works
// - Next controller state follows mode select sampled at test clock rise.
// - Code 000 captures the ring into the 69-bit register, outputs forced off.
// - Code 010 captures the ring, scans the boundary register, outputs forced off.
// - Code 100 captures and scans the ring; shifted data never reaches pins.
// - Code 111 puts the one-bit bypass register in the path.
// - Identification code loads the 32-bit fixed word and scans it out.
// - Identification word: revision 31:29, device 28:12, vendor 11:1.
// - Identification word bit zero always reads one.
// - Three-bit instruction register captures 01 in its low bits.
// - Input sampled on rising edge; output changes on falling edge from LSB.
// - Reset and power-up select identification; five high mode edges reset.
// - Update of data path with sample code does nothing, like pause.
`timescale 1ns/1ns
`include "sbst_params.svh"

module sbst_tap #(
	parameter logic [2:0]  ID_REV = `SBST_ID_REV_DFLT,
	parameter logic [16:0] ID_DEV = `SBST_ID_DEV_DFLT,
	parameter logic [10:0] ID_VEN = `SBST_ID_VEN_DFLT
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	// Test pins from the controller
	input  wire sbst_pkg::sbst_jtag_t    jtag,
	output logic                         tdo,
	output logic                         tdo_oe,
	// SRAM input and output ring
	input  wire logic [`SBST_BSR_W-1:0]  io_ring,
	output logic                         sram_hiz
);
	import sbst_pkg::*;

	localparam logic [`SBST_ID_W-1:0] ID_WORD = {ID_REV, ID_DEV, ID_VEN, 1'b1};

	sbst_jtag_t              pin_s;
	logic [`SBST_BSR_W-1:0]  ring_s;
	logic                    tck_d_r;
	logic                    tck_rise;
	logic                    tck_fall;
	sbst_state_t             state_r;
	sbst_state_t             state_nxt;
	sbst_sel_t               sel;
	logic [`SBST_IR_W-1:0]   ir_r;
	logic [`SBST_IR_W-1:0]   ir_sh_r;
	logic [`SBST_BSR_W-1:0]  bsr_r;
	logic [`SBST_ID_W-1:0]   id_sh_r;
	logic                    byp_r;
	logic                    tdo_r;
	logic                    tdo_oe_r;
	logic                    hiz_r;
	logic [2:0]              ones_cnt;

	// Pins and ring cross into mclk
	sbst_sync #(.WIDTH(3)) u_pin_sync (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.async_in (jtag),
		.sync_out (pin_s)
	);

	sbst_sync #(.WIDTH(`SBST_BSR_W)) u_ring_sync (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.async_in (io_ring),
		.sync_out (ring_s)
	);

	// Test clock edge finder
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tck_d_r <= 1'b0;
		end else begin
			tck_d_r <= pin_s.tck;
		end
	end

	assign tck_rise = pin_s.tck & ~tck_d_r;
	assign tck_fall = ~pin_s.tck & tck_d_r;

	// Next state from mode select
	always_comb begin
		unique case (state_r)
			ST_RESET:  state_nxt = pin_s.tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   state_nxt = pin_s.tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: state_nxt = pin_s.tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_nxt = pin_s.tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  state_nxt = pin_s.tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_nxt = pin_s.tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_nxt = pin_s.tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_nxt = pin_s.tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_nxt = pin_s.tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: state_nxt = pin_s.tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: state_nxt = pin_s.tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  state_nxt = pin_s.tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_nxt = pin_s.tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_nxt = pin_s.tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_nxt = pin_s.tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_nxt = pin_s.tms ? ST_SEL_DR : ST_IDLE;
		endcase
	end

	// State moves on each test clock rise
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_r <= ST_RESET;
		end else if (tck_rise) begin
			state_r <= state_nxt;
		end
	end

	// Data register chosen by the instruction; reserved codes fall to bypass
	always_comb begin
		unique case (ir_r)
			`SBST_INS_EXTEST: sel = SEL_BSR;
			`SBST_INS_SAMPZ:  sel = SEL_BSR;
			`SBST_INS_SAMPLE: sel = SEL_BSR;
			`SBST_INS_IDREAD: sel = SEL_ID;
			default:          sel = SEL_BYP;
		endcase
	end

	// Instruction shift stage: capture pattern, shift on rise
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ir_sh_r <= `SBST_IR_CAPTURE;
		end else if (tck_rise && state_r == ST_CAP_IR) begin
			ir_sh_r <= `SBST_IR_CAPTURE;
		end else if (tck_rise && state_r == ST_SH_IR) begin
			ir_sh_r <= {pin_s.tdi, ir_sh_r[`SBST_IR_W-1:1]};
		end
	end

	// Active instruction: identification at reset, update on fall
	always_ff @(posedge mclk) begin
		if (!rst_b || state_r == ST_RESET) begin
			ir_r <= `SBST_INS_IDREAD;
		end else if (tck_fall && state_r == ST_UPD_IR) begin
			ir_r <= ir_sh_r;
		end
	end

	// Boundary register: capture ring, shift; update stage is absent
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bsr_r <= '0;
		end else if (tck_rise && sel == SEL_BSR && state_r == ST_CAP_DR) begin
			bsr_r <= ring_s;
		end else if (tck_rise && sel == SEL_BSR && state_r == ST_SH_DR) begin
			bsr_r <= {pin_s.tdi, bsr_r[`SBST_BSR_W-1:1]};
		end
	end
	// Nothing reads bsr_r toward the pins and update leaves it alone

	// Identification register: fixed word on capture
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			id_sh_r <= ID_WORD;
		end else if (tck_rise && sel == SEL_ID && state_r == ST_CAP_DR) begin
			id_sh_r <= ID_WORD;
		end else if (tck_rise && sel == SEL_ID && state_r == ST_SH_DR) begin
			id_sh_r <= {pin_s.tdi, id_sh_r[`SBST_ID_W-1:1]};
		end
	end

	// Bypass bit: cleared on capture, takes serial in on shift
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			byp_r <= 1'b0;
		end else if (tck_rise && sel == SEL_BYP && state_r == ST_CAP_DR) begin
			byp_r <= 1'b0;
		end else if (tck_rise && sel == SEL_BYP && state_r == ST_SH_DR) begin
			byp_r <= pin_s.tdi;
		end
	end

	// Serial output changes on fall, driven only in shift states
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tdo_r    <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_r <= (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
			if (state_r == ST_SH_IR) begin
				tdo_r <= ir_sh_r[0];
			end else if (state_r == ST_SH_DR) begin
				unique case (sel)
					SEL_BSR: tdo_r <= bsr_r[0];
					SEL_ID:  tdo_r <= id_sh_r[0];
					SEL_BYP: tdo_r <= byp_r;
					default: tdo_r <= byp_r;
				endcase
			end
		end
	end

	// SRAM outputs forced off for the two outputs-off codes
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			hiz_r <= 1'b0;
		end else begin
			hiz_r <= (ir_r == `SBST_INS_EXTEST) || (ir_r == `SBST_INS_SAMPZ);
		end
	end

	assign tdo      = tdo_r;
	assign tdo_oe   = tdo_oe_r;
	assign sram_hiz = hiz_r;

	// Count of consecutive rises with mode select high
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ones_cnt <= 3'h0;
		end else if (tck_rise) begin
			if (!pin_s.tms) begin
				ones_cnt <= 3'h0;
			end else if (ones_cnt != `SBST_RESET_EDGES) begin
				ones_cnt <= ones_cnt + 3'h1;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	fsm_step_a: assert property (
		tck_rise && state_r == ST_RESET && !pin_s.tms |=> state_r == ST_IDLE)
		else $error("reset state did not move to idle on low mode select");

	extest_hiz_a: assert property (
		ir_r == `SBST_INS_EXTEST |=> sram_hiz)
		else $error("outputs not forced off under all-zero code");

	sampz_path_a: assert property (
		tck_fall && state_r == ST_SH_DR && ir_r == `SBST_INS_SAMPZ |=> tdo == $past(bsr_r[0]) && sram_hiz)
		else $error("outputs-off sample did not scan boundary register");

	sample_live_a: assert property (
		ir_r == `SBST_INS_SAMPLE |=> !sram_hiz)
		else $error("sample disturbed SRAM outputs");

	bypass_cap_a: assert property (
		tck_rise && state_r == ST_CAP_DR && ir_r == `SBST_INS_BYPASS |=> !byp_r)
		else $error("bypass bit not cleared on capture");

	id_cap_a: assert property (
		tck_rise && state_r == ST_CAP_DR && ir_r == `SBST_INS_IDREAD |=> id_sh_r == ID_WORD)
		else $error("identification word not loaded on capture");

	id_fields_a: assert property (
		tck_rise && state_r == ST_CAP_DR && ir_r == `SBST_INS_IDREAD
		|=> id_sh_r[31:29] == ID_REV && id_sh_r[28:12] == ID_DEV && id_sh_r[11:1] == ID_VEN)
		else $error("identification fields misplaced");

	id_lsb_a: assert property (
		tck_rise && state_r == ST_CAP_DR && ir_r == `SBST_INS_IDREAD |=> id_sh_r[0] == 1'b1)
		else $error("identification presence bit missing");

	ir_cap_a: assert property (
		tck_rise && state_r == ST_CAP_IR |=> ir_sh_r[1:0] == 2'b01)
		else $error("instruction capture pattern wrong");

	tdo_edge_a: assert property (
		$changed(tdo) |-> $past(tck_fall))
		else $error("serial output changed away from falling edge");

	reset_walk_a: assert property (
		ones_cnt == `SBST_RESET_EDGES |-> state_r == ST_RESET ##1 ir_r == `SBST_INS_IDREAD)
		else $error("five high mode edges did not reach reset");

	upd_dr_a: assert property (
		tck_rise && state_r == ST_UPD_DR |=> $stable(bsr_r) && $stable(hiz_r))
		else $error("data update changed boundary register");

	shift_exit_a: assert property (
		tck_rise && state_r == ST_SH_DR && pin_s.tms |=> state_r == ST_EX1_DR)
		else $error("shift did not exit on high mode select");

	shift_dir_a: assert property (
		tck_rise && state_r == ST_SH_DR && sel == SEL_BSR |=> bsr_r[`SBST_BSR_W-1] == $past(pin_s.tdi))
		else $error("serial in did not enter at the MSB");

endmodule

// >>> test/sbst_ctl_model.sv
// Purpose: Behavioural model of the external test controller driving the port
// Assumes: Test clock of 160 ns, low 87 ns and high 73 ns, at rest low between frames
// Notes:   Tasks are called by the bench; tdo is taken just before each rise
`timescale 1ns/1ns

module sbst_ctl_model (
	// Test pins toward the port
	output sbst_pkg::sbst_jtag_t jtag,
	input  wire logic            tdo
);
	import sbst_pkg::*;

	// Clock at rest low from time zero
	initial begin
		jtag = '0;
	end

	// One test clock period; mode select and data settle well before the rise
	task automatic step(input logic ms, input logic di, output logic o);
		jtag.tms = ms;
		jtag.tdi = di;
		#87;
		o = tdo;
		jtag.tck = 1'b1;
		#73;
		jtag.tck = 1'b0;
	endtask

	// Walks the state graph; the unused data line flips so stale values never linger
	task automatic walk(input logic [7:0] ms, input int n);
		logic o;
		for (int i = 0; i < n; i++) begin
			step(ms[i], ~jtag.tdi, o);
		end
	endtask

	// Shifts n bits LSB first, leaves through Exit1 and Update to Idle
	task automatic shift(input int n, input logic [79:0] din, output logic [79:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i]);
		end
		walk(8'h01, 2);
	endtask

	// Loads an instruction; only the five defined codes are ever sent
	task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
		logic [79:0] d;
		walk(8'h06, 5);
		shift(3, {77'h0, code}, d);
		cap = d[2:0];
	endtask

	// Scans the selected data register from Idle or reset
	task automatic scan_dr(input int n, input logic [79:0] din, output logic [79:0] dout);
		walk(8'h02, 4);
		shift(n, din, dout);
	endtask

	// Five rising edges with mode select high
	task automatic tap_reset;
		walk(8'h1f, 5);
	endtask
endmodule

// >>> test/test_sram_boundary_scan_tap.sv
// Purpose: Self-checking bench of the boundary-scan test port
// Assumes: Design defaults for the identification fields
// Notes:   Table rows cover each instruction; reset cases follow by hand
`timescale 1ns/1ns
`include "sbst_params.svh"

module test_sram_boundary_scan_tap;
	import sbst_pkg::*;

	typedef struct packed {
		logic [2:0]  code;
		logic        hiz;
		logic [6:0]  len;
		logic [68:0] cap;
	} sbst_row_t;

	localparam logic [68:0] RING = 69'h1_2345_6789_abcd_ef01;
	localparam logic [68:0] IDW  = {37'h0, `SBST_ID_REV_DFLT, `SBST_ID_DEV_DFLT, `SBST_ID_VEN_DFLT, 1'b1};
	localparam logic [79:0] DIN  = 80'h5a3c_96e1_0f87_d24b_1e2d;

	logic        mclk;
	logic        rst_b;
	sbst_jtag_t  jtag;
	logic        tdo;
	logic        tdo_oe;
	logic        tdo_line;
	logic [68:0] io_ring;
	logic        sram_hiz;
	logic [2:0]  cap3;
	int          miscompares;
	int          checks_done;
	sbst_row_t   rows [5];

	sbst_tap dut (.mclk(mclk), .rst_b(rst_b), .jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe),
		.io_ring(io_ring), .sram_hiz(sram_hiz));
	sbst_ctl_model ctl (.jtag(jtag), .tdo(tdo_line));

	// Released serial line shows the inverse of the last bit, so a missing enable corrupts the scan
	assign tdo_line = tdo_oe ? tdo : ~tdo;

	// 50 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Compares one value and counts it
	task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Scans len plus eight bits: captured word first, then the data shifted in
	task automatic scan_chk(input int len, input logic [68:0] cap);
		logic [79:0] dout;
		logic [79:0] mask;
		mask = (80'h1 << (len + 8)) - 80'h1;
		ctl.scan_dr(len + 8, DIN, dout);
		chk("dr_scan", dout, ((DIN << len) | {11'h0, cap}) & mask);
		chk("tdo_oe_idle", tdo_oe, 1'b0);
	endtask

	// Prints the counts and the verdict, then ends the run
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (50000) @(posedge mclk);
		miscompares++;
		conclude();
	end

	// Main sequence
	initial begin
		miscompares = 0;
		checks_done = 0;
		rst_b = 1'b0;
		io_ring = '0;
		rows[0] = '{`SBST_INS_EXTEST, 1'b1, 7'd69, RING};
		rows[1] = '{`SBST_INS_SAMPZ, 1'b1, 7'd69, ~RING};
		rows[2] = '{`SBST_INS_SAMPLE, 1'b0, 7'd69, RING >> 3};
		rows[3] = '{`SBST_INS_BYPASS, 1'b0, 7'd1, 69'h0};
		rows[4] = '{`SBST_INS_IDREAD, 1'b0, 7'd32, IDW};
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		for (int i = 0; i < 5; i++) begin
			@(negedge mclk);
			io_ring = (rows[i].len == 7'd69) ? rows[i].cap : ~RING;
			ctl.load_ir(rows[i].code, cap3);
			chk("ir_capture", cap3, 3'h1);
			repeat (2) @(negedge mclk);
			chk("sram_hiz", sram_hiz, rows[i].hiz);
			scan_chk(rows[i].len, rows[i].cap);
			repeat (2) @(negedge mclk);
			chk("hiz_after_update", sram_hiz, rows[i].hiz);
		end
		// Outputs forced off, then from Shift-IR exactly five high mode edges restore identification
		ctl.load_ir(`SBST_INS_EXTEST, cap3);
		ctl.walk(8'h06, 5);
		ctl.tap_reset();
		repeat (2) @(negedge mclk);
		chk("hiz_tap_reset", sram_hiz, 1'b0);
		scan_chk(32, IDW);
		// Power-up reset in mid-run while outputs are forced off
		ctl.load_ir(`SBST_INS_SAMPZ, cap3);
		repeat (2) @(negedge mclk);
		chk("hiz_before_reset", sram_hiz, 1'b1);
		rst_b = 1'b0;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		@(negedge mclk);
		chk("hiz_power_up", sram_hiz, 1'b0);
		chk("tdo_oe_power_up", tdo_oe, 1'b0);
		scan_chk(32, IDW);
		conclude();
	end
endmodule
